// ### shared/pebw_pkg.sv
// package: constants and types for the parallel eeprom host controller
package pebw_pkg;
	localparam int unsigned ADDR_W = 11;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CLK_PERIOD_NS = 40;
	// strobe low time: must exceed the 20 ns glitch filter and the 150 ns pulse minimum
	localparam int unsigned STROBE_NS = 200;
	localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// address and output enable setup before the strobe falls
	localparam int unsigned SETUP_NS = 20;
	localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// read access time, worst grade
	localparam int unsigned ACCESS_NS = 200;
	localparam int unsigned ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// power-up inhibit: host waits the longest figure before any write
	localparam int unsigned INIT_MS = 20;
	localparam int unsigned INIT_CYC = INIT_MS * 1000000 / CLK_PERIOD_NS;
	// worst-case self-timed write and chip erase pulse
	localparam int unsigned WRITE_MS = 10;
	localparam int unsigned WRITE_CYC = WRITE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned ERASE_MS = 10;
	localparam int unsigned ERASE_CYC = ERASE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 24;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h2;
	typedef enum logic [6:0] {
		PEBW_INIT = 7'h01,
		PEBW_IDLE = 7'h02,
		PEBW_SETUP = 7'h04,
		PEBW_STROBE = 7'h08,
		PEBW_RDWAIT = 7'h10,
		PEBW_BUSY = 7'h20,
		PEBW_HOLD = 7'h40
	} pebw_state_t;
endpackage

// ### src/pebw_host.sv
// host controller driving a 2k x 8 parallel eeprom through its pins
//
// Overview of operation
// RQ1: write starts with chip and write enable low, output enable high.
// RQ2: device latches address when the later of the two enables falls.
// RQ3: device latches data when the earlier of the two enables rises.
// RQ4: device erases and programs the byte alone, no more host strobes.
// RQ5: while programming, reading the last byte gives inverted bit 7.
// RQ6: after programming ends, reads return true data on all lines.
// RQ7: device blocks writes while supply is below the trip level.
// RQ8: writes are ignored 5 to 20 ms after supply rises.
// RQ9: reads work normally during the power-up inhibit.
// RQ10: no write when output enable low or either enable high.
// RQ11: strobes under 20 ns are ignored; host strobes longer.
// RQ12: chip erase: chip enable low, output enable high voltage, 10 ms write pulse.
// RQ13: open-drain ready/busy held low for the whole internal write.
// RQ14: shared ready/busy line counts busy while any device pulls low.
// RQ15: device drives data only with output and chip enable low.
// RQ16: device floats data when chip or output enable is high.
// RQ17: chip enable high deselects into standby.
// RQ18: eleven address lines pick one byte location.
// RQ19: self-timed byte write finishes within 10 ms.
// RQ20: device ignores write strobes during an internal write.
`timescale 1ns/10ps
module pebw_host
	import pebw_pkg::*;
#(
	parameter int unsigned INIT_CYCLES = INIT_CYC,
	parameter int unsigned WRITE_CYCLES = WRITE_CYC,
	parameter int unsigned ERASE_CYCLES = ERASE_CYC
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_op,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic rsp_timeout,
	output logic [ADDR_W-1:0] byte_address_lines,
	output logic chip_en_n,
	output logic write_en_n,
	output logic out_en_n,
	output logic erase_hv_en,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe,
	input wire logic ready_busy_n
);
	pebw_state_t state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [1:0] op_reg;
	logic [DATA_W-1:0] wbyte_reg;
	logic [DATA_W-1:0] data_sync;
	logic rdy_sync;
	logic poll_done;

	// pins are asynchronous to mclk
	pebw_sync #(.W(DATA_W + 1)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.async_in({ready_busy_n, data_in}),
		.sync_out({rdy_sync, data_sync})
	);

	// data_sync bit 7 shows true bit 7 and the shared line is released
	assign poll_done = rdy_sync && (data_sync[DATA_W-1] == wbyte_reg[DATA_W-1]); // see RQ5 RQ6 RQ14

	// accept requests only when idle, never during the inhibit or a write
	assign req_ready = (state_reg == PEBW_IDLE); // see RQ8 RQ20

	// main sequencer
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_reg <= PEBW_INIT;
			cnt_reg <= '0;
		end else begin
			case (state_reg)
			PEBW_INIT: begin
				// wait out the longest power-up inhibit before any write
				if (cnt_reg >= CNT_W'(INIT_CYCLES - 1)) begin // see RQ8
					state_reg <= PEBW_IDLE;
					cnt_reg <= '0;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
			PEBW_IDLE: begin
				if (req_valid) begin
					state_reg <= PEBW_SETUP;
					cnt_reg <= '0;
				end
			end
			PEBW_SETUP: begin
				if (cnt_reg >= CNT_W'(SETUP_CYC - 1)) begin
					state_reg <= (op_reg == OP_READ) ? PEBW_RDWAIT : PEBW_STROBE;
					cnt_reg <= '0;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
			PEBW_STROBE: begin
				// erase pulse is long, byte strobe well above the glitch filter;
				// cycle 0 only lowers the strobe, so the count runs one further
				if (cnt_reg >= ((op_reg == OP_ERASE) ? CNT_W'(ERASE_CYCLES)
						: CNT_W'(STROBE_CYC))) begin // see RQ11 RQ12
					state_reg <= (op_reg == OP_ERASE) ? PEBW_HOLD : PEBW_BUSY;
					cnt_reg <= '0;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
			PEBW_RDWAIT: begin
				if (cnt_reg >= CNT_W'(ACCESS_CYC + 1)) begin // covers sync delay
					state_reg <= PEBW_HOLD;
					cnt_reg <= '0;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
			PEBW_BUSY: begin
				// poll until done; give up after the worst-case write time
				if (cnt_reg > CNT_W'(SETUP_CYC + 2) && poll_done) begin // see RQ13
					state_reg <= PEBW_HOLD;
					cnt_reg <= '0;
				end else if (cnt_reg >= CNT_W'(WRITE_CYCLES - 1)) begin // see RQ19
					state_reg <= PEBW_HOLD;
					cnt_reg <= '0;
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
			PEBW_HOLD: begin
				state_reg <= PEBW_IDLE;
				cnt_reg <= '0;
			end
			default: begin
				state_reg <= PEBW_INIT;
				cnt_reg <= '0;
			end
			endcase
		end
	end

	// request capture
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			op_reg <= OP_READ;
			wbyte_reg <= '0;
			byte_address_lines <= '0;
		end else if (state_reg == PEBW_IDLE && req_valid) begin
			op_reg <= req_op;
			wbyte_reg <= req_wdata;
			byte_address_lines <= req_addr; // see RQ18
		end
	end

	// pin drive; address and data stay put across both strobe edges
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			chip_en_n <= 1'b1;
			write_en_n <= 1'b1;
			out_en_n <= 1'b1;
			erase_hv_en <= 1'b0;
			data_out <= '0;
			data_oe <= 1'b0;
		end else begin
			case (state_reg)
			PEBW_SETUP: begin
				chip_en_n <= 1'b0;
				// output enable high before write enable falls
				out_en_n <= (op_reg == OP_READ) ? 1'b0 : 1'b1; // see RQ1 RQ10
				erase_hv_en <= (op_reg == OP_ERASE); // see RQ12
				data_out <= wbyte_reg; // see RQ3
				data_oe <= (op_reg == OP_WRITE);
				write_en_n <= 1'b1;
			end
			PEBW_STROBE: begin
				// we-controlled: chip enable already low, so address latches here
				write_en_n <= (cnt_reg >= ((op_reg == OP_ERASE) ? CNT_W'(ERASE_CYCLES)
						: CNT_W'(STROBE_CYC))); // see RQ2 RQ3 RQ12
			end
			PEBW_RDWAIT: begin
				// host never drives while the device may
				data_oe <= 1'b0; // see RQ15 RQ16
				out_en_n <= 1'b0; // see RQ9
			end
			PEBW_BUSY: begin
				// release the bus and poll with read cycles only
				write_en_n <= 1'b1; // see RQ4 RQ20
				data_oe <= 1'b0;
				out_en_n <= 1'b0; // see RQ5
				chip_en_n <= 1'b0;
			end
			default: begin
				// idle: deselect into standby
				chip_en_n <= 1'b1; // see RQ17
				write_en_n <= 1'b1;
				out_en_n <= 1'b1;
				erase_hv_en <= 1'b0;
				data_oe <= 1'b0;
			end
			endcase
		end
	end

	// answer to the user, one cycle
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			rsp_timeout <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			if (state_reg == PEBW_RDWAIT && cnt_reg >= CNT_W'(ACCESS_CYC + 1)) begin
				rsp_valid <= 1'b1;
				rsp_rdata <= data_sync; // see RQ6
				rsp_timeout <= 1'b0;
			end else if (state_reg == PEBW_BUSY && cnt_reg > CNT_W'(SETUP_CYC + 2)
					&& poll_done) begin
				rsp_valid <= 1'b1;
				rsp_timeout <= 1'b0;
			end else if (state_reg == PEBW_BUSY && cnt_reg >= CNT_W'(WRITE_CYCLES - 1)) begin
				rsp_valid <= 1'b1;
				rsp_timeout <= 1'b1;
			end else if (state_reg == PEBW_STROBE && op_reg == OP_ERASE
					&& cnt_reg >= CNT_W'(ERASE_CYCLES)) begin
				rsp_valid <= 1'b1;
				rsp_timeout <= 1'b0;
			end
		end
	end

	// write enable never falls with output enable low
	chk_write_oe_high: assert property (@(posedge mclk) disable iff (reset) // see RQ1 RQ10
		$fell(write_en_n) |-> (out_en_n && !chip_en_n))
		else $error("write strobe with output enable low");

	// byte strobe lasts exactly the strobe count
	chk_strobe_width: assert property (@(posedge mclk) disable iff (reset) // see RQ11
		($fell(write_en_n) && !erase_hv_en) |-> !write_en_n [*5] ##1 write_en_n)
		else $error("byte write strobe width wrong");

	// no drive while device output is enabled
	chk_bus_contention: assert property (@(posedge mclk) disable iff (reset) // see RQ15 RQ16
		!(data_oe && !out_en_n))
		else $error("host drives data while device outputs");

	// address stable through the strobe
	chk_addr_stable: assert property (@(posedge mclk) disable iff (reset) // see RQ2 RQ3
		(!write_en_n && !$fell(write_en_n)) |-> $stable(byte_address_lines) && $stable(data_out))
		else $error("address or data moved during strobe");

	// no strobe during the power-up inhibit
	chk_init_nowrite: assert property (@(posedge mclk) disable iff (reset) // see RQ8
		(state_reg == PEBW_INIT) |-> (write_en_n && chip_en_n && !req_ready))
		else $error("access during power-up inhibit");

	// polling holds write enable high
	chk_poll_nostrobe: assert property (@(posedge mclk) disable iff (reset) // see RQ4 RQ20
		(state_reg == PEBW_BUSY) |=> (write_en_n && !data_oe))
		else $error("strobe during internal write");

	// done only when line released and true bit 7 seen
	chk_poll_done: assert property (@(posedge mclk) disable iff (reset) // see RQ5 RQ14
		(rsp_valid && !rsp_timeout && $past(state_reg) == PEBW_BUSY) |->
			$past(rdy_sync) && $past(poll_done))
		else $error("write reported done while busy");

	// erase raises high voltage only with chip enable low
	chk_erase_hv: assert property (@(posedge mclk) disable iff (reset) // see RQ12
		erase_hv_en |-> (!chip_en_n && out_en_n))
		else $error("erase voltage without chip selected");

	// idle deselects the chip
	chk_idle_standby: assert property (@(posedge mclk) disable iff (reset) // see RQ17
		(state_reg == PEBW_IDLE && $past(state_reg) == PEBW_IDLE) |-> chip_en_n)
		else $error("chip selected while idle");
endmodule

// ### src/pebw_sync.sv
// two-flop synchroniser for pins entering the mclk domain
`timescale 1ns/10ps
module pebw_sync #(
	parameter int unsigned W = 1
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;

	// first stage only feeds the second stage
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ### tb/pebw_eeprom_model.sv
// behavioural model of the 2k x 8 parallel eeprom on the far side of the host controller
`timescale 1ns/10ps
module pebw_eeprom_model
	import pebw_pkg::*;
#(
	parameter int unsigned INHIBIT_NS = 1500,
	parameter int unsigned PROG_NS = 2000,
	parameter int unsigned SLOW_NS = 12000,
	parameter int unsigned ERASE_NS = 800
) (
	input wire logic [ADDR_W-1:0] byte_address_lines,
	input wire logic chip_en_n,
	input wire logic write_en_n,
	input wire logic out_en_n,
	input wire logic erase_hv_en,
	input wire logic [DATA_W-1:0] bus_in,
	input wire logic supply_ok,
	input wire logic slow,
	output logic dev_oe,
	output logic [DATA_W-1:0] dev_data,
	output logic rb_pull
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [ADDR_W-1:0] lat_addr;
	logic [DATA_W-1:0] lat_data;
	realtime t_fall = 0;
	logic busy = 1'b0;
	logic wr_arm = 1'b0;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
	end
	// address is taken when the later enable falls; a busy array refuses new strobes
	always @(negedge write_en_n or negedge chip_en_n) begin
		if (!write_en_n && !chip_en_n) begin
			lat_addr = byte_address_lines;
			t_fall = $realtime;
			wr_arm = out_en_n && !erase_hv_en && !busy;
		end
	end
	// data is taken when the first enable rises; short pulses and low supply do nothing
	always @(posedge write_en_n or posedge chip_en_n) begin
		if (erase_hv_en && !chip_en_n && ($realtime - t_fall >= ERASE_NS)) begin
			foreach (mem[i]) mem[i] = 8'hff;
		end else if (wr_arm && supply_ok && out_en_n && ($realtime >= INHIBIT_NS)
				&& ($realtime - t_fall >= 20)) begin
			lat_data = bus_in;
			busy = 1'b1;
		end
		wr_arm = 1'b0;
	end
	// self-timed program; erase happens at once on the rising enable; slow mode overruns the limit on command only
	always @(posedge busy) begin
		#(slow ? SLOW_NS : PROG_NS);
		mem[lat_addr] = lat_data;
		busy = 1'b0;
	end
	// drive only when selected with output enable low; polling shows inverted bit 7
	assign dev_oe = !chip_en_n && !out_en_n && !erase_hv_en;
	assign dev_data = (busy && byte_address_lines == lat_addr) ?
		{~lat_data[7], lat_data[6:0] ^ 7'h2a} : mem[byte_address_lines];
	assign rb_pull = busy;
endmodule

// ### tb/pebw_host_tb.sv
// self-checking bench for the parallel eeprom host controller
`timescale 1ns/10ps
module pebw_host_tb;
	import pebw_pkg::*;
	logic mclk, reset, req_valid, req_ready, rsp_valid, rsp_timeout;
	logic [1:0] req_op;
	logic [ADDR_W-1:0] req_addr, byte_address_lines;
	logic [DATA_W-1:0] req_wdata, rsp_rdata, data_in, data_out, dev_data, flt;
	logic chip_en_n, write_en_n, out_en_n, erase_hv_en, data_oe, dev_oe, rb_pull;
	logic rb_other, slow, ready_busy_n;
	logic [DATA_W-1:0] mirror [0:(1<<ADDR_W)-1];
	logic [ADDR_W-1:0] ra [0:5];
	logic [31:0] seed;
	int num_errors, n_checks, cycles, lat;
	// host drive wins, then the device; a released bus shows a moving pattern
	assign data_in = data_oe ? data_out : (dev_oe ? dev_data : flt);
	assign ready_busy_n = !(rb_pull || rb_other);
	pebw_host #(.INIT_CYCLES(50), .WRITE_CYCLES(200), .ERASE_CYCLES(20)) dut (
		.mclk(mclk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
		.req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout),
		.byte_address_lines(byte_address_lines), .chip_en_n(chip_en_n),
		.write_en_n(write_en_n), .out_en_n(out_en_n), .erase_hv_en(erase_hv_en),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ready_busy_n(ready_busy_n));
	pebw_eeprom_model partner (
		.byte_address_lines(byte_address_lines), .chip_en_n(chip_en_n),
		.write_en_n(write_en_n), .out_en_n(out_en_n), .erase_hv_en(erase_hv_en),
		.bus_in(data_in), .supply_ok(1'b1), .slow(slow), .dev_oe(dev_oe),
		.dev_data(dev_data), .rb_pull(rb_pull));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// floating pattern and hang guard
	always @(posedge mclk) begin
		flt <= {flt[6:0], ~flt[7]};
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			num_errors++;
			$display("Error at %0t: run did not finish", $time);
			complete_run();
		end
	end
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one request, held until taken, then a bounded wait for the answer
	task automatic xfer(input logic [1:0] op, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 100) begin
			@(posedge mclk);
			#1 n++;
		end
		// a request that is never taken is a failure, not a silent retry
		if (n >= 100) begin
			num_errors++;
			$display("Error at %0t: request never taken", $time);
		end
		req_valid = 1'b1;
		req_op = op;
		req_addr = a;
		req_wdata = d;
		@(posedge mclk);
		#1 req_valid = 1'b0;
		lat = 1;
		while (rsp_valid !== 1'b1 && lat < 1000) begin
			@(posedge mclk);
			#1 lat++;
		end
		if (lat >= 1000) begin
			num_errors++;
			$display("Error at %0t: no answer to request", $time);
		end
	endtask
	// a write may only finish after the device's 50-cycle program time
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		xfer(OP_WRITE, a, d);
		mirror[a] = d;
		check({7'h0, rsp_timeout}, 8'h00);
		check({7'h0, lat >= 50}, 8'h01);
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a);
		xfer(OP_READ, a, 8'h00);
		check(rsp_rdata, mirror[a]);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		req_valid = 1'b0;
		req_op = OP_READ;
		req_addr = 11'h000;
		req_wdata = 8'h00;
		rb_other = 1'b0;
		slow = 1'b0;
		flt = 8'ha5;
		cycles = 0;
		num_errors = 0;
		n_checks = 0;
		seed = 32'h00000849;
		foreach (mirror[i]) mirror[i] = 8'hff;
		repeat (3) @(posedge mclk);
		#1 reset = 1'b0;
		// boundary addresses, both bit 7 values, back-to-back rewrite of one byte
		wr(11'h000, 8'h00);
		wr(11'h7ff, 8'h80);
		wr(11'h7ff, 8'h7f);
		rd_chk(11'h000);
		rd_chk(11'h7ff);
		$display("test corner done");
		// random bytes to random places, read back afterwards
		for (int i = 0; i < 6; i++) begin
			seed = next_rand(seed);
			ra[i] = seed[10:0];
			wr(seed[10:0], seed[23:16]);
		end
		for (int i = 0; i < 6; i++) rd_chk(ra[i]);
		$display("test random done");
		// a second device holds the shared ready line low for 100 cycles
		rb_other = 1'b1;
		fork
			begin
				repeat (100) @(posedge mclk);
				#1 rb_other = 1'b0;
			end
		join_none
		wr(11'h155, 8'h3c);
		check({7'h0, lat > 100}, 8'h01);
		rd_chk(11'h155);
		$display("test shared ready done");
		// device that overruns the write time makes the host report a timeout
		slow = 1'b1;
		xfer(OP_WRITE, 11'h2aa, 8'hc3);
		mirror[11'h2aa] = 8'hc3;
		check({7'h0, rsp_timeout}, 8'h01);
		repeat (120) @(posedge mclk);
		#1 slow = 1'b0;
		rd_chk(11'h2aa);
		$display("test timeout done");
		// chip erase sets every byte to ones
		xfer(OP_ERASE, 11'h000, 8'h00);
		foreach (mirror[i]) mirror[i] = 8'hff;
		rd_chk(ra[0]);
		rd_chk(11'h2aa);
		wr(ra[1], 8'h5a);
		rd_chk(ra[1]);
		$display("test erase done");
		complete_run();
	end
endmodule
